// *** rtl/wds_device.sv ***
/*
 * wds_device: descriptor store answering get descriptor requests; set requests stall.
 * Assumes requests arrive from logic on sys_clk, one at a time, while
 * busy is low; the connected level comes from the device state machine.
 */
`timescale 1ns/1ps
module wds_device #(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] PRODUCT_ID = 16'h5678, // arbitrary value
    parameter logic [7:0] NUM_CAPS = 8'h01
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // device state
    input wire logic connected,
    // link
    wds_link_if.device link
);
    typedef enum logic [2:0] {
        WDS_IDLE = 3'b001,
        WDS_SEND = 3'b010,
        WDS_DONE = 3'b100
    } wds_state_t;

    // one capability in the set; adding more needs a longer image
    localparam logic [15:0] BOS_TOTAL =
        {8'h00, wds_pkg::BOS_HDR_LEN} + {8'h00, wds_pkg::CAP_LEN};
    // the capability sits right behind the header
    localparam logic [4:0] CAP_BASE = wds_pkg::BOS_HDR_LEN[4:0];

    wds_state_t state;
    logic sel; // 0 device, 1 bos set
    logic [15:0] pos;
    logic [15:0] count;
    logic [7:0] next_byte;
    logic accept;
    logic refuse;
    logic [15:0] total;
    // request classes
    logic is_get;
    logic is_forbidden;
    logic is_direct_cap;
    logic is_stored;
    // byte images, indexed by position within the answer
    logic [7:0] dev_rom [32];
    logic [7:0] bos_rom [32];

    // request classes; forbidden and capability types never answer
    assign is_get = (link.req_code == wds_pkg::REQ_GET_DESC);
    assign is_forbidden = (link.req_type inside {wds_pkg::DT_DEV_QUAL,
        wds_pkg::DT_OTHER_SPEED, wds_pkg::DT_IF_POWER,
        wds_pkg::DT_OTG});
    assign is_direct_cap = (link.req_type == wds_pkg::DT_DEV_CAP);
    assign is_stored = (link.req_type == wds_pkg::DT_DEVICE) ||
        (link.req_type == wds_pkg::DT_BOS);

    // decode the request; only device and bos are stored here
    always_comb begin
        accept = 1'b0;
        refuse = 1'b0;
        if (link.req_valid && state == WDS_IDLE) begin
            if (!connected) begin
                refuse = 1'b1;
            end else if (!is_get || is_direct_cap) begin
                // set descriptor and direct capability reads stall
                refuse = 1'b1;
            end else if (is_forbidden) begin
                refuse = 1'b1;
            end else if (is_stored) begin
                accept = 1'b1;
            end else begin
                // types held by other parts of the device also stall
                refuse = 1'b1;
            end
        end
    end

    // descriptor size of the selected object
    assign total = (link.req_type == wds_pkg::DT_BOS) ? BOS_TOTAL :
        {8'h00, wds_pkg::DEV_LEN};

    // device descriptor image; fields not listed stay zero
    always_comb begin
        dev_rom = '{default: 8'h00};
        dev_rom[wds_pkg::DEV_OFS_LEN] = wds_pkg::DEV_LEN;
        dev_rom[wds_pkg::DEV_OFS_TYPE] = wds_pkg::DT_DEVICE;
        dev_rom[wds_pkg::DEV_OFS_BCD] = wds_pkg::DEV_BCD_USB[7:0];
        dev_rom[wds_pkg::DEV_OFS_BCD + 5'd1] =
            wds_pkg::DEV_BCD_USB[15:8];
        dev_rom[wds_pkg::DEV_OFS_MAX_PKT0] = wds_pkg::DEV_MAX_PKT0;
        dev_rom[wds_pkg::DEV_OFS_VENDOR] = VENDOR_ID[7:0];
        dev_rom[wds_pkg::DEV_OFS_VENDOR + 5'd1] = VENDOR_ID[15:8];
        dev_rom[wds_pkg::DEV_OFS_PRODUCT] = PRODUCT_ID[7:0];
        dev_rom[wds_pkg::DEV_OFS_PRODUCT + 5'd1] = PRODUCT_ID[15:8];
        dev_rom[wds_pkg::DEV_OFS_NUM_CFG] = wds_pkg::DEV_NUM_CFG;
    end

    // bos image: header, then the capability, never apart
    always_comb begin
        bos_rom = '{default: 8'h00};
        bos_rom[wds_pkg::BOS_OFS_LEN] = wds_pkg::BOS_HDR_LEN;
        bos_rom[wds_pkg::BOS_OFS_TYPE] = wds_pkg::DT_BOS;
        bos_rom[wds_pkg::BOS_OFS_TOTAL] = BOS_TOTAL[7:0];
        bos_rom[wds_pkg::BOS_OFS_TOTAL + 5'd1] = BOS_TOTAL[15:8];
        bos_rom[wds_pkg::BOS_OFS_NCAP] = NUM_CAPS;
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_LEN] =
            wds_pkg::CAP_LEN;
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_DTYPE] =
            wds_pkg::DT_DEV_CAP;
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_TYPE] =
            wds_pkg::CAP_WIRELESS;
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_BODY] =
            wds_pkg::CAP_ATTR;
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_RATES] =
            wds_pkg::CAP_PHY_RATES[7:0];
        bos_rom[CAP_BASE + wds_pkg::CAP_OFS_RATES + 5'd1] =
            wds_pkg::CAP_PHY_RATES[15:8];
    end

    // byte at the current position; count keeps pos inside the image
    assign next_byte = sel ? bos_rom[pos[4:0]] : dev_rom[pos[4:0]];

    // transfer state; zero length goes straight to done
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= WDS_IDLE;
        end else if (clk_en) begin
            unique case (state)
                WDS_IDLE: begin
                    if (accept) begin
                        state <= (link.req_length == 16'h0000) ?
                            WDS_DONE : WDS_SEND;
                    end
                end
                WDS_SEND: begin
                    if (pos + 16'h0001 == count) begin
                        state <= WDS_DONE;
                    end
                end
                WDS_DONE: begin
                    state <= WDS_IDLE;
                end
                default: state <= WDS_IDLE;
            endcase
        end
    end

    // object and length are latched as the request is taken
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sel <= 1'b0;
            count <= 16'h0000;
        end else if (clk_en && accept) begin
            sel <= (link.req_type == wds_pkg::DT_BOS);
            // short request truncates, zero sends nothing
            count <= (link.req_length < total) ?
                link.req_length : total;
        end
    end

    // byte position; restarts at the first byte of every answer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pos <= 16'h0000;
        end else if (clk_en) begin
            if (accept) begin
                pos <= 16'h0000;
            end else if (state == WDS_SEND) begin
                pos <= pos + 16'h0001;
            end
        end
    end

    // registered outputs toward the host
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link.data_valid <= 1'b0;
            link.data_byte <= 8'h00;
            link.data_last <= 1'b0;
            link.stall <= 1'b0;
            link.busy <= 1'b0;
        end else if (clk_en) begin
            link.data_valid <= (state == WDS_SEND);
            link.data_byte <= (state == WDS_SEND) ? next_byte : 8'h00;
            link.data_last <= (state == WDS_SEND) &&
                (pos + 16'h0001 == count);
            link.stall <= refuse;
            link.busy <= accept || (state == WDS_SEND);
        end
    end
endmodule

// *** rtl/wds_pkg.sv ***
/*
 * wds_pkg: shared constants for the wireless descriptor store.
 * Holds descriptor type codes, fixed field values and layout offsets.
 * Assumes both ends of the descriptor link import nothing; use wds_pkg::.
 */
package wds_pkg;
    // standard request codes
    localparam logic [7:0] REQ_GET_DESC = 8'h06;
    localparam logic [7:0] REQ_SET_DESC = 8'h07;
    // standard descriptor types
    localparam logic [7:0] DT_DEVICE = 8'h01;
    localparam logic [7:0] DT_CONFIG = 8'h02;
    localparam logic [7:0] DT_STRING = 8'h03;
    localparam logic [7:0] DT_DEV_QUAL = 8'h06;
    localparam logic [7:0] DT_OTHER_SPEED = 8'h07;
    localparam logic [7:0] DT_IF_POWER = 8'h08;
    localparam logic [7:0] DT_OTG = 8'h09;
    // wireless extension descriptor types
    localparam logic [7:0] DT_SECURITY = 8'h0c;
    localparam logic [7:0] DT_KEY = 8'h0d;
    localparam logic [7:0] DT_ENC_TYPE = 8'h0e;
    localparam logic [7:0] DT_BOS = 8'h0f;
    localparam logic [7:0] DT_DEV_CAP = 8'h10;
    localparam logic [7:0] DT_WEP_COMP = 8'h11;
    // capability type codes
    localparam logic [7:0] CAP_WIRELESS = 8'h01;
    // device descriptor fixed fields
    localparam logic [7:0] DEV_LEN = 8'h12;
    localparam logic [15:0] DEV_BCD_USB = 16'h0250;
    localparam logic [7:0] DEV_MAX_PKT0 = 8'hff;
    localparam logic [7:0] DEV_NUM_CFG = 8'h01;
    // device descriptor field positions
    localparam logic [4:0] DEV_OFS_LEN = 5'h00;
    localparam logic [4:0] DEV_OFS_TYPE = 5'h01;
    localparam logic [4:0] DEV_OFS_BCD = 5'h02;
    localparam logic [4:0] DEV_OFS_MAX_PKT0 = 5'h07;
    localparam logic [4:0] DEV_OFS_VENDOR = 5'h08;
    localparam logic [4:0] DEV_OFS_PRODUCT = 5'h0a;
    localparam logic [4:0] DEV_OFS_NUM_CFG = 5'h11;
    // bos layout
    localparam logic [7:0] BOS_HDR_LEN = 8'h05;
    localparam logic [4:0] BOS_OFS_LEN = 5'h00;
    localparam logic [4:0] BOS_OFS_TYPE = 5'h01;
    localparam logic [4:0] BOS_OFS_TOTAL = 5'h02;
    localparam logic [4:0] BOS_OFS_NCAP = 5'h04;
    // capability field positions, from the capability's first byte
    localparam logic [4:0] CAP_OFS_LEN = 5'h00;
    localparam logic [4:0] CAP_OFS_DTYPE = 5'h01;
    localparam logic [4:0] CAP_OFS_TYPE = 5'h02;
    localparam logic [4:0] CAP_OFS_BODY = 5'h03;
    localparam logic [4:0] CAP_OFS_RATES = 5'h04;
    // wireless capability: header plus attr, rates(2), five spare bytes
    localparam logic [7:0] CAP_LEN = 8'h0b;
    localparam logic [7:0] CAP_ATTR = 8'h04; // directed beacon
    localparam logic [15:0] CAP_PHY_RATES = 16'h0001;
endpackage

// *** rtl/wds_link_if.sv ***
/*
 * wds_link_if: request and byte stream between host and device ends.
 * Assumes both ends run on one sys_clk; no tristate lines.
 */
`timescale 1ns/1ps
interface wds_link_if;
    // request, host to device
    logic req_valid;
    logic [7:0] req_code;
    logic [7:0] req_type;
    logic [7:0] req_index;
    logic [15:0] req_length;
    // answer, device to host
    logic data_valid;
    logic [7:0] data_byte;
    logic data_last;
    logic stall;
    logic busy;

    modport device (
        input req_valid, req_code, req_type, req_index, req_length,
        output data_valid, data_byte, data_last, stall, busy
    );
    modport host (
        output req_valid, req_code, req_type, req_index, req_length,
        input data_valid, data_byte, data_last, stall, busy
    );
endinterface

// *** rtl/wds_host.sv ***
/*
 * wds_host: requesting end; issues one descriptor request and
 * passes answer bytes to its user.
 * Assumes user holds cmd_go for one cycle only while cmd_ready is high.
 */
`timescale 1ns/1ps
module wds_host (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // user command
    input wire logic cmd_go,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_type,
    input wire logic [15:0] cmd_length,
    output logic cmd_ready,
    // user answer
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_last,
    output logic rsp_stall,
    // link
    wds_link_if.host link
);
    // request strobe; the length goes out as the user gives it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link.req_valid <= 1'b0;
            link.req_code <= 8'h00;
            link.req_type <= 8'h00;
            link.req_index <= 8'h00;
            link.req_length <= 16'h0000;
        end else if (clk_en) begin
            link.req_valid <= cmd_go && cmd_ready;
            if (cmd_go && cmd_ready) begin
                link.req_code <= cmd_code;
                link.req_type <= cmd_type;
                link.req_length <= cmd_length;
            end
        end
    end

    // ready only after the previous answer has ended
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cmd_ready <= 1'b1;
        end else if (clk_en) begin
            if (cmd_go && cmd_ready) begin
                cmd_ready <= 1'b0;
            end else if (link.stall || link.data_last ||
                         (!link.busy && !link.req_valid &&
                          !link.data_valid)) begin
                cmd_ready <= 1'b1;
            end
        end
    end

    // answer pass-through, registered
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
            rsp_byte <= 8'h00;
            rsp_last <= 1'b0;
            rsp_stall <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= link.data_valid;
            rsp_byte <= link.data_byte;
            rsp_last <= link.data_last;
            rsp_stall <= link.stall;
        end
    end
endmodule

// *** testbench/wds_link_monitor.sv ***
/* wds_link_monitor: assertions on the link between the two ends.
   assumes clk_en drops only while the link is idle, one request
   at a time. */
`timescale 1ns/1ps
module wds_link_monitor (
    // clock, reset and device state
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic connected,
    // link signals
    input wire logic req_valid,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_type,
    input wire logic [15:0] req_length,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    input wire logic data_last,
    input wire logic stall,
    input wire logic busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // requests the device is free to take; busy ones are ignored
    logic take;
    logic get_ok;
    assign take = req_valid && !busy;
    assign get_ok = take && connected && req_code == wds_pkg::REQ_GET_DESC;

    chk_absent_refuse: assert property (
        take && !connected |=> stall && !busy)
        else $error("request while not connected was not refused");
    chk_forbidden_type: assert property (
        take && req_type inside {8'h06, 8'h07, 8'h08, 8'h09} |=> stall)
        else $error("forbidden descriptor type was not refused");
    chk_direct_cap: assert property (
        take && (req_type == wds_pkg::DT_DEV_CAP
        || req_code == wds_pkg::REQ_SET_DESC) |=> stall)
        else $error("direct capability or set request not refused");
    chk_bos_header: assert property (
        get_ok && req_type == 8'h0f && req_length > 16'h0004 |=> busy
        ##1 data_valid && data_byte == 8'h05 ##1 data_byte == 8'h0f
        ##1 data_byte == 8'h10 ##1 data_byte == 8'h00 ##1 data_byte == 8'h01)
        else $error("bos header bytes wrong");
    chk_dev_fields: assert property (
        get_ok && req_type == 8'h01 && req_length > 16'h0011 |->
        ##4 data_byte == 8'h50 ##1 data_byte == 8'h02 ##4 data_byte == 8'hff)
        else $error("device descriptor version or packet size wrong");
    chk_cap_header: assert property (
        data_valid && !data_last && data_byte == 8'h10 &&
        $past(data_byte) == 8'h0b |=> data_valid && data_byte == 8'h01)
        else $error("capability subtype byte wrong");
    chk_short_read: assert property (
        get_ok && req_type == 8'h0f && req_length == 16'h0001 |->
        ##2 data_valid && data_last ##1 !data_valid)
        else $error("one byte bos read not cut short");
    chk_last_valid: assert property (
        data_last |-> data_valid && !stall)
        else $error("last flag without a data byte");
    chk_stall_pulse: assert property (
        stall |=> !stall && !data_valid)
        else $error("refusal held or followed by data");
endmodule

// *** testbench/wireless_descriptor_store_tb_top.sv ***
/* wireless_descriptor_store_tb_top: host and device ends joined by the
   link, answers compared with a bench model. assumes zero ids. */
`timescale 1ns/1ps
module wireless_descriptor_store_tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic connected = 1'b0;
    logic clk_en = 1'b1;
    logic cmd_go = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_type = 8'h00;
    logic [15:0] cmd_length = 16'h0000;
    logic cmd_ready, rsp_valid, rsp_last, rsp_stall;
    logic [7:0] rsp_byte;
    logic [7:0] types[14] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h00};
    logic [15:0] lens[5] = '{16'h0001, 16'h0005, 16'h0010, 16'h0011,
        16'h0028};
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    wds_link_if link ();
    wds_device #(.VENDOR_ID(16'h0000), .PRODUCT_ID(16'h0000),
        .NUM_CAPS(8'h01)) u_wds_device (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .connected(connected), .link(link.device));
    wds_host u_wds_host (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .cmd_go(cmd_go), .cmd_code(cmd_code), .cmd_type(cmd_type),
        .cmd_length(cmd_length), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
        .rsp_stall(rsp_stall), .link(link.host));
    wds_link_monitor u_wds_link_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
        .connected(connected), .req_valid(link.req_valid),
        .req_code(link.req_code), .req_type(link.req_type),
        .req_length(link.req_length), .data_valid(link.data_valid),
        .data_byte(link.data_byte), .data_last(link.data_last),
        .stall(link.stall), .busy(link.busy));

    // free running clock and a hang limit far above the expected run
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one request through the host end, answer compared with the model
    task automatic run(input logic [7:0] code, input logic [7:0] typ,
        input logic [15:0] len);
        int d[$];
        logic [7:0] got[$];
        logic stalled;
        logic last_seen;
        int n;
        stalled = 1'b0;
        last_seen = 1'b0;
        if (typ == 8'h01) d = {18, 1, 'h50, 2, 0, 0, 0, 'hff, 0, 0, 0, 0,
            0, 0, 0, 0, 0, 1};
        if (typ == 8'h0f) d = {5, 15, 16, 0, 1, 11, 16, 1, 4, 1, 0, 0, 0,
            0, 0, 0};
        if (!connected || code != 8'h06) d = {};
        n = (len < d.size()) ? len : d.size();
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        cmd_code = code;
        cmd_type = typ;
        cmd_length = len;
        cmd_go = 1'b1;
        @(negedge sys_clk);
        cmd_go = 1'b0;
        repeat (200) begin
            @(negedge sys_clk);
            if (rsp_valid === 1'b1) got.push_back(rsp_byte);
            if (rsp_stall === 1'b1) stalled = 1'b1;
            if (rsp_last === 1'b1) last_seen = 1'b1;
            if (last_seen === 1'b1 || stalled === 1'b1) break;
        end
        check("refusal", {15'h0, d.size() == 0}, {15'h0, stalled});
        check("byte count", 16'(n), 16'(got.size()));
        check("last flag", {15'h0, n > 0}, {15'h0, last_seen});
        check("ready", 16'h0001, {15'h0, cmd_ready});
        for (int i = 0; i < n && i < got.size(); i++)
            check("data byte", 16'(d[i]), {8'h00, got[i]});
        $display("test done code %h type %h length %0d", code, typ, len);
    endtask

    // main sequence: absent, every type, set, lengths, random mix
    initial begin
        void'($urandom(49));
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        run(8'h06, 8'h01, 16'h0012);
        connected = 1'b1;
        foreach (types[i]) run(8'h06, types[i], 16'h0040);
        run(8'h07, 8'h0f, 16'h0010);
        run(8'h07, 8'h10, 16'h000b);
        foreach (lens[i]) run(8'h06, 8'h0f, lens[i]);
        // frozen clock enable: a command must not reach the link
        clk_en = 1'b0;
        cmd_go = 1'b1;
        @(negedge sys_clk);
        cmd_go = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("frozen strobe", 16'h0000, {15'h0, link.req_valid});
        check("frozen ready", 16'h0001, {15'h0, cmd_ready});
        clk_en = 1'b1;
        $display("test done frozen clock enable");
        repeat (20) run(8'h06, types[$urandom % 14],
            16'($urandom % 40 + 1));
        wrap_up();
    end
endmodule
